// *** src/vpa_pkg.sv ***
package vpa_pkg;

    // Gains are unsigned with eight fraction bits, so 0x100 is unity.
    localparam int         VPA_GAIN_W     = 10;
    localparam int         VPA_GAIN_FRAC  = 8;
    localparam logic [9:0] VPA_GAIN_UNITY = 10'h100;
    // Half and double gain bound every gain to roughly +/-6 dB.
    localparam logic [9:0] VPA_GAIN_MIN   = 10'h080;
    localparam logic [9:0] VPA_GAIN_MAX   = 10'h200;

    // Black offset register width; the value is two's complement.
    localparam int         VPA_OFS_W      = 10;
    localparam logic [9:0] VPA_OFS_RST    = 10'h000;

    // Register byte addresses on the Avalon-MM slave.
    localparam int         VPA_ADDR_W     = 5;
    localparam logic [4:0] VPA_ADR_CTRL   = 5'h00;
    localparam logic [4:0] VPA_ADR_YGAIN  = 5'h04;
    localparam logic [4:0] VPA_ADR_CBGAIN = 5'h08;
    localparam logic [4:0] VPA_ADR_CRGAIN = 5'h0C;
    localparam logic [4:0] VPA_ADR_BLKOFS = 5'h10;
    localparam logic [4:0] VPA_ADR_SYNCG  = 5'h14;
    localparam logic [4:0] VPA_ADR_CHRG   = 5'h18;
    localparam logic [4:0] VPA_ADR_BLKLVL = 5'h1C;

    // Control register fields; all three loops come up switched on.
    localparam int         VPA_CTRL_SYNC_LOOP   = 0;
    localparam int         VPA_CTRL_CHROMA_LOOP = 1;
    localparam int         VPA_CTRL_BLACK_TRACK = 2;
    localparam logic [2:0] VPA_CTRL_RST         = 3'h7;

    // Loop dead band and leaky average shift of the level trackers.
    localparam int         VPA_LOOP_HYST   = 4;
    localparam int         VPA_TRACK_SHIFT = 4;

    typedef enum logic [1:0] {
        VPA_BUS_IDLE = 2'b01,
        VPA_BUS_ACK  = 2'b10
    } vpa_bus_e;

endpackage

// *** src/vpa_scale.sv ***
`timescale 1ns/10ps
`default_nettype none

module vpa_scale
    import vpa_pkg::*;
#(
    parameter int IW         = 12,
    parameter int OW         = 10,
    parameter bit SIGNED_OUT = 1'b0
) (
    // Sample in
    input  wire logic signed [IW-1:0]        sample,
    input  wire logic        [VPA_GAIN_W:0]  gain,
    input  wire logic        [VPA_OFS_W-1:0] offset,
    // Sample out
    output logic             [OW-1:0]        result
);

    localparam int SW = IW + 5;
    localparam logic signed [SW-1:0] HI = SIGNED_OUT ?
        SW'((1 << (OW - 1)) - 1) : SW'((1 << OW) - 1);
    localparam logic signed [SW-1:0] LO = SIGNED_OUT ?
        SW'(-(1 << (OW - 1))) : '0;

    logic signed [IW+11:0] prod;
    logic signed [SW-1:0]  sum;

    assign prod = sample * $signed({1'b0, gain});
    assign sum  = $signed({prod[IW+11], prod[IW+11:VPA_GAIN_FRAC]})
                + $signed({{(SW-VPA_OFS_W){offset[VPA_OFS_W-1]}}, offset});

    // Clipping keeps highlights from folding into black.
    always_comb begin
        if (sum > HI) begin
            result = HI[OW-1:0];
        end else if (sum < LO) begin
            result = LO[OW-1:0];
        end else begin
            result = sum[OW-1:0];
        end
    end

endmodule

`default_nettype wire

// *** src/vpa_top.sv ***
// Notes on behaviour
// - Sync loop on: luma gain steers measured sync height to its reference.
// - Automatic luma gain stays between half and double, about +/-6 dB.
// - Sync loop off: automatic luma gain is unity, only manual gain scales luma.
// - Manual luma gain multiplies with the automatic luma gain.
// - Chroma loop on: chroma gain steers measured burst height to reference.
// - Automatic chroma gain stays between half and double, about +/-6 dB.
// - Chroma loop off: automatic chroma gain is unity.
// - Manual Cb and Cr gains multiply with the automatic chroma gain.
// - A control bit switches black tracking on or off on its own.
// - Black tracking measures black level and subtracts it from luma.
// - Manual black offset is added whether or not black tracking runs.
// - Manual luma gain is clamped to about +/-6 dB.
// - Separate Cb and Cr gains, each clamped to about +/-6 dB.
// - A signed offset is added to the luma output as brightness.
// - Gain and offset act on combed samples, registered once to the output.
`timescale 1ns/10ps
`default_nettype none

module vpa_top
    import vpa_pkg::*;
#(
    parameter int DW        = 10,
    parameter int SYNC_REF  = 192,
    parameter int BURST_REF = 96
) (
    // Clock and reset
    input  wire logic                  mclk,
    input  wire logic                  rst_n,
    // Avalon-MM slave
    input  wire logic [VPA_ADDR_W-1:0] avs_address,
    input  wire logic                  avs_read,
    input  wire logic                  avs_write,
    input  wire logic [31:0]           avs_writedata,
    output logic      [31:0]           avs_readdata,
    output logic                       avs_waitrequest,
    // Combed video in
    input  wire logic                  vin_valid,
    input  wire logic [DW-1:0]         vin_y,
    input  wire logic [DW-1:0]         vin_cb,
    input  wire logic [DW-1:0]         vin_cr,
    input  wire logic                  vin_sync,
    input  wire logic                  vin_burst,
    input  wire logic                  vin_black,
    // Processed video out
    output logic                       vout_valid,
    output logic      [DW-1:0]         vout_y,
    output logic      [DW-1:0]         vout_cb,
    output logic      [DW-1:0]         vout_cr
);

    localparam int MW = DW + 2;
    localparam logic [MW-1:0] SYNC_LO  = MW'(SYNC_REF - VPA_LOOP_HYST);
    localparam logic [MW-1:0] SYNC_HI  = MW'(SYNC_REF + VPA_LOOP_HYST);
    localparam logic [MW-1:0] BURST_LO = MW'(BURST_REF - VPA_LOOP_HYST);
    localparam logic [MW-1:0] BURST_HI = MW'(BURST_REF + VPA_LOOP_HYST);

    typedef struct packed {
        vpa_bus_e                bus;
        logic [31:0]             rdata;
        logic [2:0]              ctrl;
        logic [VPA_GAIN_W-1:0]   ygain;
        logic [VPA_GAIN_W-1:0]   cbgain;
        logic [VPA_GAIN_W-1:0]   crgain;
        logic [VPA_OFS_W-1:0]    blk_ofs;
        logic [VPA_GAIN_W-1:0]   sync_gain;
        logic [VPA_GAIN_W-1:0]   chroma_gain;
        logic [DW-1:0]           blk_lvl;
        logic [DW-1:0]           tip_lvl;
        logic [DW-1:0]           burst_pk;
        logic                    sync_d;
        logic                    burst_d;
        logic                    vout_valid;
        logic [DW-1:0]           y;
        logic [DW-1:0]           cb;
        logic [DW-1:0]           cr;
    } vpa_state_s;

    localparam vpa_state_s ST_RST = '{
        bus:         VPA_BUS_IDLE,
        rdata:       '0,
        ctrl:        VPA_CTRL_RST,
        ygain:       VPA_GAIN_UNITY,
        cbgain:      VPA_GAIN_UNITY,
        crgain:      VPA_GAIN_UNITY,
        blk_ofs:     VPA_OFS_RST,
        sync_gain:   VPA_GAIN_UNITY,
        chroma_gain: VPA_GAIN_UNITY,
        blk_lvl:     '0,
        tip_lvl:     '0,
        burst_pk:    '0,
        sync_d:      1'b0,
        burst_d:     1'b0,
        vout_valid:  1'b0,
        y:           '0,
        cb:          '0,
        cr:          '0
    };

    vpa_state_s st_reg;
    vpa_state_s st_next;

    // Software may write any value; the gain range is enforced here.
    function automatic logic [VPA_GAIN_W-1:0] clamp_gain(
        input logic [VPA_GAIN_W-1:0] g
    );
        if (g < VPA_GAIN_MIN) begin
            return VPA_GAIN_MIN;
        end else if (g > VPA_GAIN_MAX) begin
            return VPA_GAIN_MAX;
        end else begin
            return g;
        end
    endfunction

    // Product of two gains, back to eight fraction bits.
    function automatic logic [VPA_GAIN_W:0] mix_gain(
        input logic [VPA_GAIN_W-1:0] a,
        input logic [VPA_GAIN_W-1:0] b
    );
        logic [2*VPA_GAIN_W-1:0] p;
        p = a * b;
        return p[VPA_GAIN_W+VPA_GAIN_FRAC:VPA_GAIN_FRAC];
    endfunction

    // Datapath, one channel per scaler: luma, Cb, Cr.
    logic signed [MW-1:0]        ch_in   [3];
    logic        [VPA_GAIN_W:0]  ch_gain [3];
    logic        [VPA_OFS_W-1:0] ch_ofs  [3];
    logic        [DW-1:0]        ch_out  [3];
    logic        [DW-1:0]        blk_sub;

    // The tracked level is removed only while tracking is switched on.
    assign blk_sub = st_reg.ctrl[VPA_CTRL_BLACK_TRACK] ?
                     st_reg.blk_lvl : '0;
    assign ch_in[0]   = $signed({2'b00, vin_y}) - $signed({2'b00, blk_sub});
    assign ch_in[1]   = $signed({{2{vin_cb[DW-1]}}, vin_cb});
    assign ch_in[2]   = $signed({{2{vin_cr[DW-1]}}, vin_cr});
    assign ch_gain[0] = mix_gain(st_reg.ygain, st_reg.sync_gain);
    assign ch_gain[1] = mix_gain(st_reg.cbgain, st_reg.chroma_gain);
    assign ch_gain[2] = mix_gain(st_reg.crgain, st_reg.chroma_gain);
    assign ch_ofs[0]  = st_reg.blk_ofs;
    assign ch_ofs[1]  = '0;
    assign ch_ofs[2]  = '0;

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_chan
            vpa_scale #(
                .IW         (MW),
                .OW         (DW),
                .SIGNED_OUT (gi != 0)
            ) u_scale (
                .sample (ch_in[gi]),
                .gain   (ch_gain[gi]),
                .offset (ch_ofs[gi]),
                .result (ch_out[gi])
            );
        end
    endgenerate

    // Level measurements feeding both loops.
    logic                 sync_end;
    logic                 burst_end;
    logic [DW-1:0]        sync_amp;
    logic [DW-1:0]        cb_abs;
    logic [DW-1:0]        cr_abs;
    logic [DW-1:0]        chroma_abs;
    logic [MW-1:0]        sync_meas;
    logic [MW-1:0]        burst_meas;
    logic [DW+VPA_GAIN_W-1:0] sync_prod;
    logic [DW+VPA_GAIN_W-1:0] burst_prod;

    assign sync_end   = st_reg.sync_d & ~vin_sync;
    assign burst_end  = st_reg.burst_d & ~vin_burst;
    assign sync_amp   = (st_reg.blk_lvl > st_reg.tip_lvl) ?
                        st_reg.blk_lvl - st_reg.tip_lvl : '0;
    assign cb_abs     = vin_cb[DW-1] ? DW'(-vin_cb) : vin_cb;
    assign cr_abs     = vin_cr[DW-1] ? DW'(-vin_cr) : vin_cr;
    assign chroma_abs = (cb_abs > cr_abs) ? cb_abs : cr_abs;
    // Compare after the loop's own gain so each loop converges on the ref.
    assign sync_prod  = sync_amp * st_reg.sync_gain;
    assign burst_prod = st_reg.burst_pk * st_reg.chroma_gain;
    assign sync_meas  = sync_prod[DW+VPA_GAIN_W-1:VPA_GAIN_FRAC];
    assign burst_meas = burst_prod[DW+VPA_GAIN_W-1:VPA_GAIN_FRAC];

    // Leaky average step towards the current sample.
    function automatic logic [DW-1:0] track(
        input logic [DW-1:0] lvl,
        input logic [DW-1:0] smp
    );
        logic signed [DW:0] diff;
        logic signed [DW:0] sum;
        diff = $signed({1'b0, smp}) - $signed({1'b0, lvl});
        sum  = $signed({1'b0, lvl}) + (diff >>> VPA_TRACK_SHIFT);
        return sum[DW-1:0];
    endfunction

    always_comb begin
        st_next            = st_reg;
        st_next.sync_d     = vin_sync;
        st_next.burst_d    = vin_burst;
        st_next.vout_valid = vin_valid;
        if (vin_valid) begin
            st_next.y  = ch_out[0];
            st_next.cb = ch_out[1];
            st_next.cr = ch_out[2];
            if (vin_black) begin
                st_next.blk_lvl = track(st_reg.blk_lvl, vin_y);
            end
            if (vin_sync) begin
                st_next.tip_lvl = track(st_reg.tip_lvl, vin_y);
            end
            if (vin_burst && !st_reg.burst_d) begin
                st_next.burst_pk = chroma_abs;
            end else if (vin_burst && chroma_abs > st_reg.burst_pk) begin
                st_next.burst_pk = chroma_abs;
            end
        end
        if (!st_reg.ctrl[VPA_CTRL_SYNC_LOOP]) begin
            st_next.sync_gain = VPA_GAIN_UNITY;
        end else if (sync_end) begin
            if (sync_meas < SYNC_LO && st_reg.sync_gain < VPA_GAIN_MAX) begin
                st_next.sync_gain = st_reg.sync_gain + 10'h001;
            end else if (sync_meas > SYNC_HI &&
                         st_reg.sync_gain > VPA_GAIN_MIN) begin
                st_next.sync_gain = st_reg.sync_gain - 10'h001;
            end
        end
        if (!st_reg.ctrl[VPA_CTRL_CHROMA_LOOP]) begin
            st_next.chroma_gain = VPA_GAIN_UNITY;
        end else if (burst_end) begin
            if (burst_meas < BURST_LO &&
                st_reg.chroma_gain < VPA_GAIN_MAX) begin
                st_next.chroma_gain =
                    st_reg.chroma_gain + 10'h001;
            end else if (burst_meas > BURST_HI &&
                         st_reg.chroma_gain > VPA_GAIN_MIN) begin
                st_next.chroma_gain =
                    st_reg.chroma_gain - 10'h001;
            end
        end
        // A request waits one cycle, then completes on the second edge.
        case (st_reg.bus)
            VPA_BUS_IDLE: begin
                if (avs_read || avs_write) begin
                    st_next.bus   = VPA_BUS_ACK;
                    st_next.rdata = '0;
                    if (avs_read) begin
                        case (avs_address)
                            VPA_ADR_CTRL:   st_next.rdata[2:0] = st_reg.ctrl;
                            VPA_ADR_YGAIN:  st_next.rdata[9:0] = st_reg.ygain;
                            VPA_ADR_CBGAIN: st_next.rdata[9:0] = st_reg.cbgain;
                            VPA_ADR_CRGAIN: st_next.rdata[9:0] = st_reg.crgain;
                            VPA_ADR_BLKOFS: st_next.rdata[9:0] =
                                                st_reg.blk_ofs;
                            VPA_ADR_SYNCG:  st_next.rdata[9:0] =
                                                st_reg.sync_gain;
                            VPA_ADR_CHRG:   st_next.rdata[9:0] =
                                                st_reg.chroma_gain;
                            VPA_ADR_BLKLVL: st_next.rdata[DW-1:0] =
                                                st_reg.blk_lvl;
                            default:        st_next.rdata = '0;
                        endcase
                    end
                end
            end
            VPA_BUS_ACK: begin
                st_next.bus = VPA_BUS_IDLE;
                if (avs_write) begin
                    case (avs_address)
                        VPA_ADR_CTRL:   st_next.ctrl =
                            avs_writedata[2:0];
                        VPA_ADR_YGAIN:  st_next.ygain =
                            clamp_gain(avs_writedata[9:0]);
                        VPA_ADR_CBGAIN: st_next.cbgain =
                            clamp_gain(avs_writedata[9:0]);
                        VPA_ADR_CRGAIN: st_next.crgain =
                            clamp_gain(avs_writedata[9:0]);
                        VPA_ADR_BLKOFS: st_next.blk_ofs =
                            avs_writedata[VPA_OFS_W-1:0];
                        default:        st_next.bus = VPA_BUS_IDLE;
                    endcase
                end
            end
            default: begin
                st_next.bus = VPA_BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st_reg <= ST_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    assign avs_waitrequest = (avs_read | avs_write) &
                             (st_reg.bus != VPA_BUS_ACK);
    assign avs_readdata    = st_reg.rdata;
    assign vout_valid      = st_reg.vout_valid;
    assign vout_y          = st_reg.y;
    assign vout_cb         = st_reg.cb;
    assign vout_cr         = st_reg.cr;

    // Expected luma when every gain is unity and tracking is off.
    logic signed [MW-1:0] exp_sum;
    logic        [DW-1:0] exp_y;
    assign exp_sum = $signed({2'b00, vin_y}) + $signed(
        {{(MW-VPA_OFS_W){st_reg.blk_ofs[VPA_OFS_W-1]}}, st_reg.blk_ofs});
    assign exp_y = exp_sum[MW-1] ? '0 :
                   (exp_sum[MW-2:DW] != '0) ? '1 : exp_sum[DW-1:0];

    property p_sync_off;
        @(posedge mclk) disable iff (!rst_n)
        !st_reg.ctrl[VPA_CTRL_SYNC_LOOP] |=>
            st_reg.sync_gain == VPA_GAIN_UNITY;
    endproperty
    a_sync_off: assert property (p_sync_off)
        else $error("Luma gain not unity with sync loop off.");

    property p_sync_range;
        @(posedge mclk) disable iff (!rst_n)
        st_reg.sync_gain >= VPA_GAIN_MIN && st_reg.sync_gain <= VPA_GAIN_MAX;
    endproperty
    a_sync_range: assert property (p_sync_range)
        else $error("Automatic luma gain outside its range.");

    property p_sync_up;
        @(posedge mclk) disable iff (!rst_n)
        st_reg.ctrl[VPA_CTRL_SYNC_LOOP] && sync_end && sync_meas < SYNC_LO &&
        st_reg.sync_gain < VPA_GAIN_MAX |=>
            st_reg.sync_gain == $past(st_reg.sync_gain) + 10'h001;
    endproperty
    a_sync_up: assert property (p_sync_up)
        else $error("Small sync did not raise the luma gain.");

    property p_chroma_off;
        @(posedge mclk) disable iff (!rst_n)
        !st_reg.ctrl[VPA_CTRL_CHROMA_LOOP] |=>
            st_reg.chroma_gain == VPA_GAIN_UNITY;
    endproperty
    a_chroma_off: assert property (p_chroma_off)
        else $error("Chroma gain not unity with chroma loop off.");

    property p_chroma_range;
        @(posedge mclk) disable iff (!rst_n)
        st_reg.chroma_gain inside {[VPA_GAIN_MIN:VPA_GAIN_MAX]};
    endproperty
    a_chroma_range: assert property (p_chroma_range)
        else $error("Automatic chroma gain outside its range.");

    property p_chroma_down;
        @(posedge mclk) disable iff (!rst_n)
        st_reg.ctrl[VPA_CTRL_CHROMA_LOOP] && burst_end &&
        burst_meas > BURST_HI && st_reg.chroma_gain > VPA_GAIN_MIN |=>
            st_reg.chroma_gain == $past(st_reg.chroma_gain) - 10'h001;
    endproperty
    a_chroma_down: assert property (p_chroma_down)
        else $error("Large burst did not lower the chroma gain.");

    property p_ygain_clamp;
        @(posedge mclk) disable iff (!rst_n)
        st_reg.bus == VPA_BUS_ACK && avs_write &&
        avs_address == VPA_ADR_YGAIN && avs_writedata[9:0] > VPA_GAIN_MAX
        |=> st_reg.ygain == VPA_GAIN_MAX;
    endproperty
    a_ygain_clamp: assert property (p_ygain_clamp)
        else $error("Manual luma gain not clamped.");

    property p_offset;
        @(posedge mclk) disable iff (!rst_n)
        vin_valid && st_reg.ygain == VPA_GAIN_UNITY &&
        st_reg.sync_gain == VPA_GAIN_UNITY &&
        !st_reg.ctrl[VPA_CTRL_BLACK_TRACK] |=> vout_y == $past(exp_y);
    endproperty
    a_offset: assert property (p_offset)
        else $error("Luma output is not input plus black offset.");

    property p_black_track;
        @(posedge mclk) disable iff (!rst_n)
        vin_valid && vin_black && vin_y > st_reg.blk_lvl |=>
            st_reg.blk_lvl >= $past(st_reg.blk_lvl);
    endproperty
    a_black_track: assert property (p_black_track)
        else $error("Black level moved away from the input.");

    property p_stream;
        @(posedge mclk) disable iff (!rst_n)
        vin_valid |=> vout_valid;
    endproperty
    a_stream: assert property (p_stream)
        else $error("Output sample missing one cycle after input.");

    property p_bus_answer;
        @(posedge mclk) disable iff (!rst_n)
        (avs_read || avs_write) && st_reg.bus == VPA_BUS_IDLE |=>
            !avs_waitrequest;
    endproperty
    a_bus_answer: assert property (p_bus_answer)
        else $error("Bus request not answered on the second edge.");

endmodule

`default_nettype wire

// *** testbench/vpa_src.sv ***
`timescale 1ns/10ps
`default_nettype none

module vpa_src
    import vpa_pkg::*;
#(
    parameter int DW = 10
) (
    // Clock and reset
    input  wire logic            mclk,
    input  wire logic            rst_n,
    // Bench command: pixel {y, cb, cr} and flags {sync, burst, black}
    input  wire logic            cmd_valid,
    input  wire logic [3*DW-1:0] cmd_pix,
    input  wire logic [2:0]      cmd_flag,
    // Combed video towards the amplifier
    output logic                 vin_valid,
    output logic [3*DW-1:0]      vin_pix,
    output logic [2:0]           vin_flag
);
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            vin_valid <= 1'b0;
            vin_pix   <= '0;
            vin_flag  <= 3'h0;
        end else if (cmd_valid) begin
            vin_valid <= 1'b1;
            vin_pix   <= cmd_pix;
            vin_flag  <= cmd_flag;
        end else begin
            // Idle data toggles so a block that samples it by mistake shows.
            vin_valid <= 1'b0;
            vin_pix   <= ~vin_pix;
            vin_flag  <= 3'h0;
        end
    end
endmodule

`default_nettype wire

// *** testbench/testbench.sv ***
`timescale 1ns/10ps
`default_nettype none

module testbench;
    import vpa_pkg::*;
    logic        mclk = 1'b0;
    logic        rst_n = 1'b0;
    logic [4:0]  avs_address = 5'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        cmd_valid = 1'b0;
    logic [29:0] cmd_pix = 30'h0000_0000;
    logic [2:0]  cmd_flag = 3'h0;
    logic        vin_valid;
    logic [29:0] vin_pix;
    logic [2:0]  vin_flag;
    logic        vout_valid;
    logic [9:0]  vout_y;
    logic [9:0]  vout_cb;
    logic [9:0]  vout_cr;
    logic [31:0] rd;
    int          mismatches = 0;
    int          n_compared = 0;
    int          b;

    initial begin
        forever #5 mclk = ~mclk;
    end

    vpa_top u_vpa_top (.mclk(mclk), .rst_n(rst_n),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .vin_valid(vin_valid), .vin_y(vin_pix[29:20]),
        .vin_cb(vin_pix[19:10]), .vin_cr(vin_pix[9:0]),
        .vin_sync(vin_flag[2]), .vin_burst(vin_flag[1]),
        .vin_black(vin_flag[0]), .vout_valid(vout_valid),
        .vout_y(vout_y), .vout_cb(vout_cb), .vout_cr(vout_cr));

    vpa_src u_vpa_src (.mclk(mclk), .rst_n(rst_n), .cmd_valid(cmd_valid),
        .cmd_pix(cmd_pix), .cmd_flag(cmd_flag), .vin_valid(vin_valid),
        .vin_pix(vin_pix), .vin_flag(vin_flag));

    task end_of_test;
        $display("Compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task tmo;
        $display("[ERR] %0t wait ran out", $time);
        mismatches++;
        end_of_test;
    endtask

    task cmp(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // One Avalon transfer; an edge passes after release so calls can chain.
    task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        int i;
        avs_address   <= a;
        avs_write     <= wr;
        avs_read      <= ~wr;
        avs_writedata <= d;
        for (i = 0; i < 20; i++) begin
            @(posedge mclk);
            if (avs_waitrequest === 1'b0) break;
        end
        if (i == 20) tmo;
        rd = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        @(posedge mclk);
    endtask

    task rdc(input logic [4:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        cmp(rd, exp);
    endtask

    // Leaves cmd_valid high; the caller drops it, so valid is never
    // assigned twice in one time step.
    task px(input logic [9:0] y, input logic [9:0] cb, input logic [9:0] cr,
            input logic [2:0] f);
        cmd_valid <= 1'b1;
        cmd_pix   <= {y, cb, cr};
        cmd_flag  <= f;
        @(posedge mclk);
    endtask

    task pxc(input logic [9:0] y, input logic [9:0] cb, input logic [9:0] cr,
             input logic [9:0] ey, input logic [9:0] ecb,
             input logic [9:0] ecr);
        int i;
        px(y, cb, cr, 3'h0);
        cmd_valid <= 1'b0;
        for (i = 0; i < 8; i++) begin
            @(posedge mclk);
            #1;
            if (vout_valid === 1'b1) break;
        end
        if (i == 8) tmo;
        cmp(32'(i), 32'h0000_0000);
        cmp(vout_y, ey);
        cmp(vout_cb, ecb);
        cmp(vout_cr, ecr);
        @(posedge mclk);
    endtask

    task line(input logic [9:0] bk, input logic [9:0] cb);
        px(10'h000, 10'h000, 10'h000, 3'h4);
        px(10'h000, 10'h000, 10'h000, 3'h4);
        px(bk, cb, 10'h000, 3'h2);
        px(bk, cb, 10'h000, 3'h2);
        px(bk, 10'h000, 10'h000, 3'h1);
        cmd_valid <= 1'b0;
        @(posedge mclk);
    endtask

    initial begin
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        rdc(VPA_ADR_CTRL, 32'h0000_0007);
        rdc(VPA_ADR_YGAIN, 32'h0000_0100);
        rdc(VPA_ADR_CRGAIN, 32'h0000_0100);
        rdc(VPA_ADR_BLKOFS, 32'h0000_0000);
        bus(1'b1, VPA_ADR_SYNCG, 32'h0000_0155);
        rdc(VPA_ADR_SYNCG, 32'h0000_0100);
        rdc(5'h02, 32'h0000_0000);
        $display("test reset map done");
        bus(1'b1, VPA_ADR_CTRL, 32'h0000_0000);
        bus(1'b1, VPA_ADR_YGAIN, 32'h0000_0200);
        bus(1'b1, VPA_ADR_CBGAIN, 32'h0000_0080);
        bus(1'b1, VPA_ADR_CRGAIN, 32'h0000_0200);
        pxc(10'h12C, 10'h064, 10'h2D4, 10'h258, 10'h032, 10'h200);
        pxc(10'h258, 10'h000, 10'h000, 10'h3FF, 10'h000, 10'h000);
        bus(1'b1, VPA_ADR_YGAIN, 32'h0000_03FF);
        rdc(VPA_ADR_YGAIN, 32'h0000_0200);
        bus(1'b1, VPA_ADR_YGAIN, 32'h0000_0010);
        rdc(VPA_ADR_YGAIN, 32'h0000_0080);
        bus(1'b1, VPA_ADR_YGAIN, 32'h0000_0100);
        bus(1'b1, VPA_ADR_BLKOFS, 32'h0000_03EC);
        rdc(VPA_ADR_BLKOFS, 32'h0000_03EC);
        pxc(10'h00A, 10'h000, 10'h000, 10'h000, 10'h000, 10'h000);
        pxc(10'h064, 10'h000, 10'h000, 10'h050, 10'h000, 10'h000);
        $display("test manual trims done");
        bus(1'b1, VPA_ADR_BLKOFS, 32'h0000_0005);
        bus(1'b1, VPA_ADR_CTRL, 32'h0000_0004);
        b = 0;
        repeat (40) begin
            px(10'h040, 10'h000, 10'h000, 3'h1);
            b = b + ((64 - b) >>> 4);
        end
        cmd_valid <= 1'b0;
        @(posedge mclk);
        rdc(VPA_ADR_BLKLVL, 32'(b));
        pxc(10'h0C8, 10'h000, 10'h000, 10'(205-b), 10'h000, 10'h000);
        bus(1'b1, VPA_ADR_CTRL, 32'h0000_0000);
        pxc(10'h0C8, 10'h000, 10'h000, 10'h0CD, 10'h000, 10'h000);
        $display("test black tracking done");
        bus(1'b1, VPA_ADR_BLKOFS, 32'h0000_0000);
        bus(1'b1, VPA_ADR_CBGAIN, 32'h0000_0100);
        bus(1'b1, VPA_ADR_YGAIN, 32'h0000_0200);
        bus(1'b1, VPA_ADR_CTRL, 32'h0000_0003);
        // Tall sync and burst drive both loops down to their floor.
        repeat (420) line(10'h3E8, 10'h0FA);
        rdc(VPA_ADR_SYNCG, 32'h0000_0080);
        rdc(VPA_ADR_CHRG, 32'h0000_0080);
        pxc(10'h320, 10'h064, 10'h39C, 10'h320, 10'h032, 10'h39C);
        repeat (420) line(10'h3E8, 10'h014);
        rdc(VPA_ADR_CHRG, 32'h0000_0200);
        rdc(VPA_ADR_SYNCG, 32'h0000_0080);
        bus(1'b1, VPA_ADR_CTRL, 32'h0000_0000);
        rdc(VPA_ADR_SYNCG, 32'h0000_0100);
        rdc(VPA_ADR_CHRG, 32'h0000_0100);
        $display("test gain loops done");
        end_of_test;
    end
endmodule

`default_nettype wire
